// *** mul_unit_pkg.sv ***
// Purpose: shared constants for the multiply instruction unit
// Assumes: 16-bit instruction words, 8-bit data, four-phase instruction cycle
// Notes:   opcodes compared on the upper instruction bits only
package mul_unit_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PROD_W = 16;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned ADDR_W = 12;
  // -------------------------------------------------------------
  // opcode fields, address limits and product reset value
  // -------------------------------------------------------------
  localparam logic [7:0] LIT_OPCODE = 8'h0d;
  localparam logic [6:0] REG_OPCODE = 7'h01;
  localparam int unsigned BANK_BIT = 8;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [7:0] PROD_RESET = 8'h00;
  // -------------------------------------------------------------
  // instruction phases
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;
endpackage

// *** mul_operand_addr.sv ***
// Purpose: forms the data-memory address of the register operand
// Assumes: bank select and indirect base supplied by the core
// Notes:   purely combinational
`timescale 1ns/1ps
module mul_operand_addr (
  input  wire logic [7:0]  i_file_addr,
  input  wire logic        i_bank_mode,
  input  wire logic        i_ext_enable,
  input  wire logic [3:0]  i_bank_select,
  input  wire logic [11:0] i_index_base,
  output logic      [11:0] o_addr
);
  always_comb begin
    if (i_bank_mode) begin
      o_addr = {i_bank_select, i_file_addr};
    end else if (i_ext_enable && (i_file_addr <= mul_unit_pkg::INDEXED_LIMIT)) begin
      o_addr = i_index_base + {4'h0, i_file_addr};
    end else if (i_file_addr < mul_unit_pkg::ACCESS_SPLIT) begin
      o_addr = {4'h0, i_file_addr};
    end else begin
      o_addr = {mul_unit_pkg::ACCESS_HIGH_BANK, i_file_addr};
    end
  end
endmodule

// *** multiply_instruction_unit.sv ***
// Purpose: executes the literal and register multiply instructions
// Assumes: decoder presents the instruction word for a whole cycle
// Notes:   operand read in read phase, product written in write phase
`timescale 1ns/1ps
module multiply_instruction_unit (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_instr,
  input  wire logic        i_instr_valid,
  input  wire logic [1:0]  i_phase,
  input  wire logic [7:0]  i_accum,
  input  wire logic        i_ext_enable,
  input  wire logic [3:0]  i_bank_select,
  input  wire logic [11:0] i_index_base,
  input  wire logic [7:0]  i_mem_rdata,
  input  wire logic        i_prod_high_we,
  input  wire logic        i_prod_low_we,
  input  wire logic [7:0]  i_prod_wdata,
  output logic      [11:0] o_mem_addr,
  output logic             o_mem_rd,
  output logic             o_busy,
  output logic      [7:0]  o_product_high_byte,
  output logic      [7:0]  o_product_low_byte
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic        is_lit;
  logic        is_reg;
  logic        is_mul;
  logic        bank_mode;
  logic [7:0]  file_addr;
  logic [7:0]  literal;
  logic [11:0] addr;

  // opcode compared on the upper bits only; the low byte is payload
  assign is_lit    = i_instr_valid && (i_instr[15:8] == mul_unit_pkg::LIT_OPCODE);
  assign is_reg    = i_instr_valid && (i_instr[15:9] == mul_unit_pkg::REG_OPCODE);
  assign is_mul    = is_lit || is_reg;
  assign bank_mode = i_instr[mul_unit_pkg::BANK_BIT];
  assign file_addr = i_instr[7:0];
  assign literal   = i_instr[7:0];

  mul_operand_addr u_addr (
    .i_file_addr   (file_addr),
    .i_bank_mode   (bank_mode),
    .i_ext_enable  (i_ext_enable),
    .i_bank_select (i_bank_select),
    .i_index_base  (i_index_base),
    .o_addr        (addr)
  );

  // ---------------------------------------------------------------
  // phase strobes
  // ---------------------------------------------------------------
  logic in_read;
  logic in_process;
  logic in_write;

  assign in_read    = (i_phase == mul_unit_pkg::PH_READ);
  assign in_process = (i_phase == mul_unit_pkg::PH_PROCESS);
  assign in_write   = (i_phase == mul_unit_pkg::PH_WRITE);

  // ---------------------------------------------------------------
  // data memory port
  // ---------------------------------------------------------------
  // read request only; the accumulator and the source are never written
  assign o_mem_addr = addr;
  assign o_mem_rd   = is_reg && in_read;
  assign o_busy     = is_mul;

  // ---------------------------------------------------------------
  // operand capture
  // ---------------------------------------------------------------
  logic [7:0] operand_src;
  logic [7:0] operand_reg;
  logic [7:0] operand_next;

  // literal comes from the word itself, register from data memory
  assign operand_src = is_lit ? literal : i_mem_rdata;

  always_comb begin
    operand_next = operand_reg;
    if (is_mul && in_read) begin
      operand_next = operand_src;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      operand_reg <= 8'h00;
    end else begin
      operand_reg <= operand_next;
    end
  end

  // ---------------------------------------------------------------
  // shift-and-add array
  // ---------------------------------------------------------------
  // one partial product per operand bit, summed in a ripple chain;
  // the chain is long but only has to settle within the process phase
  logic [15:0] acc_wide;
  logic [15:0] partial [8];
  logic [15:0] running [9];
  logic [15:0] array_product;

  assign acc_wide   = {8'h00, i_accum};
  assign running[0] = 16'h0000;

  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx++) begin : g_row
      // a zero operand bit contributes nothing to its row
      assign partial[bit_idx]     = operand_reg[bit_idx] ? (acc_wide << bit_idx) : 16'h0000;
      assign running[bit_idx + 1] = running[bit_idx] + partial[bit_idx];
    end
  endgenerate

  // 8x8 unsigned never exceeds 16 bits, so the last sum drops nothing
  assign array_product = running[8];

  // ---------------------------------------------------------------
  // result register
  // ---------------------------------------------------------------
  logic [15:0] result_reg;
  logic [15:0] result_next;

  // no carry, overflow or zero indication is derived from the sum
  always_comb begin
    result_next = result_reg;
    if (is_mul && in_process) begin
      result_next = array_product;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_reg <= 16'h0000;
    end else begin
      result_reg <= result_next;
    end
  end

  // ---------------------------------------------------------------
  // product registers
  // ---------------------------------------------------------------
  logic       mul_write;
  logic [7:0] prod_high_reg;
  logic [7:0] prod_high_next;
  logic [7:0] prod_low_reg;
  logic [7:0] prod_low_next;

  // the write phase of a multiply wins over a direct write in the same cycle
  assign mul_write = is_mul && in_write;

  always_comb begin
    prod_high_next = prod_high_reg;
    if (mul_write) begin
      prod_high_next = result_reg[15:8];
    end else if (i_prod_high_we) begin
      prod_high_next = i_prod_wdata;
    end
  end

  always_comb begin
    prod_low_next = prod_low_reg;
    if (mul_write) begin
      prod_low_next = result_reg[7:0];
    end else if (i_prod_low_we) begin
      prod_low_next = i_prod_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prod_high_reg <= mul_unit_pkg::PROD_RESET;
    end else begin
      prod_high_reg <= prod_high_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prod_low_reg <= mul_unit_pkg::PROD_RESET;
    end else begin
      prod_low_reg <= prod_low_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // no status outputs exist, so flags cannot change
  assign o_product_high_byte = prod_high_reg;
  assign o_product_low_byte  = prod_low_reg;
endmodule

// *** mul_mem_model.sv ***
// Purpose: data memory seen by the operand read
// Assumes: contents are a fixed function of the address
// Notes:   reads inverted data when not selected
`timescale 1ns/1ps
module mul_mem_model (
  input  wire logic [11:0] i_addr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata
);
  assign o_rdata = {8{~i_rd}} ^ i_addr[7:0] ^ {2{i_addr[11:8]}};
endmodule

// *** mul_unit_checker.sv ***
// Purpose: port checks of the multiply unit
// Assumes: accumulator held for a whole instruction
// Notes:   a multiply write beats a direct write
`timescale 1ns/1ps
module mul_unit_checker (
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_instr_valid,
  input wire logic        i_ext_enable,
  input wire logic        i_prod_high_we,
  input wire logic        o_mem_rd,
  input wire logic        o_busy,
  input wire logic [15:0] i_instr,
  input wire logic [1:0]  i_phase,
  input wire logic [7:0]  i_accum,
  input wire logic [7:0]  i_mem_rdata,
  input wire logic [7:0]  i_prod_wdata,
  input wire logic [7:0]  o_product_high_byte,
  input wire logic [7:0]  o_product_low_byte,
  input wire logic [3:0]  i_bank_select,
  input wire logic [11:0] i_index_base,
  input wire logic [11:0] o_mem_addr
);
  logic lit, rg, mw;
  logic [15:0] prod;
  assign prod = {o_product_high_byte, o_product_low_byte};
  assign lit = i_instr_valid && i_instr[15:8] == mul_unit_pkg::LIT_OPCODE;
  assign rg = i_instr_valid && i_instr[15:9] == mul_unit_pkg::REG_OPCODE;
  assign mw = (lit || rg) && i_phase == 2'h3;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_reg_op;
    rg && i_phase == 2'h1 ##1 rg && i_phase == 2'h2 ##1 mw;
  endsequence
  a_busy_on_mul: assert property (lit || rg |-> o_busy) else $error("busy low");
  a_idle_other: assert property (i_instr_valid && !lit && !rg |-> !o_busy) else $error("busy");
  a_reg_read: assert property (rg && i_phase == 2'h1 |-> o_mem_rd) else $error("no read");
  a_lit_prod: assert property (lit && mw |=>
    prod == {8'h00, $past(i_accum)} * {8'h00, $past(i_instr[7:0])}) else $error("literal product");
  a_reg_prod: assert property (s_reg_op |=>
    prod == {8'h00, $past(i_accum)} * {8'h00, $past(i_mem_rdata, 3)}) else $error("register product");
  a_prod_hold: assert property (!mw && !i_prod_high_we |=>
    $stable(o_product_high_byte)) else $error("product moved");
  a_direct_wr: assert property (!mw && i_prod_high_we |=>
    o_product_high_byte == $past(i_prod_wdata)) else $error("direct write");
  a_bank_addr: assert property (rg && i_instr[8] |->
    o_mem_addr == {i_bank_select, i_instr[7:0]}) else $error("bank address");
  a_index_addr: assert property (rg && !i_instr[8] && i_ext_enable && i_instr[7:0] <= 8'h5f
    |-> o_mem_addr == i_index_base + 12'(i_instr[7:0])) else $error("indexed address");
endmodule
bind multiply_instruction_unit mul_unit_checker chk (.*);

// *** multiply_instruction_unit_tb.sv ***
// Purpose: random and corner multiplies against a memory model
// Assumes: phases driven one clock each
// Notes:   expectations come from bench functions, one fixed literal product and the held product
`timescale 1ns/1ps
module multiply_instruction_unit_tb;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, ext = 1'b0, hw = 1'b0, lw = 1'b0, rd, busy, lit;
  logic [15:0] w = 16'h0000, ex;
  logic [1:0] ph = 2'h0;
  logic [7:0] acc = 8'h00, bs8, wd = 8'h00, rdat, hi, lo;
  logic [3:0] bs = 4'h0;
  logic [11:0] base = 12'h000, addr;
  int failures = 0, checks = 0, seed = 10242;
  multiply_instruction_unit uut (.i_clock(clk), .i_rst_n(rst_n), .i_instr(w), .i_instr_valid(vld),
    .i_phase(ph), .i_accum(acc), .i_ext_enable(ext), .i_bank_select(bs), .i_index_base(base),
    .i_mem_rdata(rdat), .i_prod_high_we(hw), .i_prod_low_we(lw), .i_prod_wdata(wd),
    .o_mem_addr(addr), .o_mem_rd(rd), .o_busy(busy), .o_product_high_byte(hi),
    .o_product_low_byte(lo));
  mul_mem_model mem (.i_addr(addr), .i_rd(rd), .o_rdata(rdat));
  initial forever #2.5 clk = ~clk;
  function automatic logic [11:0] ea(logic [15:0] i, logic e, logic [3:0] b, logic [11:0] x);
    if (i[8]) return {b, i[7:0]};
    if (e && i[7:0] <= 8'h5f) return x + 12'(i[7:0]);
    return {(i[7:0] < 8'h60) ? 4'h0 : 4'hf, i[7:0]};
  endfunction
  // memory model contents as a function of the address
  function automatic logic [7:0] mem_val(logic [11:0] a);
    return a[7:0] ^ {2{a[11:8]}};
  endfunction
  function automatic logic mul_op(logic [15:0] i);
    return (i[15:8] == 8'h0d) || (i[15:9] == 7'h01);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [15:0] i);
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      w <= i;
      vld <= 1'b1;
      ph <= p[1:0];
    end
    #1 chk(16'(busy), 16'(mul_op(i)));
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({hi, lo}, 16'h0000);
    acc <= 8'he2;
    op(16'h0dc4);
    chk({hi, lo}, 16'had08);
    $display("done: literal example");
    for (int n = 0; n < 40; n++) begin
      ex = 16'($random(seed));
      lit = ex[9] && (n >= 4);
      if (lit) ex[15:8] = 8'h0d;
      else ex[15:9] = 7'h01;
      if (n < 4) ex[8:0] = {1'b0, n[0] ? 8'h5f : 8'h60};
      {ext, bs, base, acc} <= 25'($random(seed));
      #1 bs8 = lit ? ex[7:0] : mem_val(ea(ex, ext, bs, base));
      op(ex);
      chk({hi, lo}, {8'h00, acc} * {8'h00, bs8});
    end
    $display("done: random multiplies");
    ex = {hi, lo};
    op(16'h6e55);
    chk({hi, lo}, ex);
    hw <= 1'b1;
    wd <= 8'h3c;
    @(posedge clk) hw <= 1'b0;
    #1 chk({hi, lo}, {8'h3c, ex[7:0]});
    lw <= 1'b1;
    wd <= 8'ha7;
    @(posedge clk) lw <= 1'b0;
    #1 chk({hi, lo}, 16'h3ca7);
    $display("done: hold and direct writes");
    report_and_stop();
  end
endmodule
